// file: rtl/apcm_defs.vh
/*
  Constants for the serial audio port clock monitor: register offset, fault
  field positions, detection timing and supported rate classes.
  Assumes a 40 MHz system clock and inclusion by bare name.
*/
`ifndef APCM_DEFS_VH
`define APCM_DEFS_VH
`define APCM_GLOBAL_FAULT_FLAGS_ADDR 8'h71
`define APCM_GLOBAL_FAULT_FLAGS_RESET 8'h00
`define APCM_CLOCK_ERROR_BIT 2
`define APCM_CLK_HZ 40000000
`define APCM_HALT_TIME_NS 20000
`define APCM_HALT_CYCLES ((`APCM_HALT_TIME_NS * (`APCM_CLK_HZ / 1000000)) / 1000)
`define APCM_CLEAR_CODE 8'h04
`define APCM_RATE_NONE 3'h0
`define APCM_RATE_32K 3'h1
`define APCM_RATE_48K 3'h2
`define APCM_RATE_96K 3'h3
`define APCM_RATE_192K 3'h4
`define APCM_FMT_TWO_CH 1'b0
`define APCM_FMT_TDM 1'b1
`endif

// file: rtl/apcm_sync.v
/*
  Two-flop synchroniser with a registered edge detector behind it.
  Assumes the input is asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/1ps
module apcm_sync (
  input wire clk,
  input wire rst,
  input wire async_in,
  output reg level,
  output reg rise,
  output reg fall
);
  reg stage1;
  reg stage2;

  always @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      level <= stage2;
      rise <= stage2 & ~level;
      fall <= ~stage2 & level;
    end
  end
endmodule

// file: rtl/apcm_top.v
/*
  Receive side of a three-wire serial audio port with clock supervision.
  Bit clock, word/frame clock and data arrive from the host and are
  oversampled by the 40 MHz system clock. The PLL itself is analog; here it
  is represented by the lock/run control it receives.
  Assumes a free-running clk and a host that keeps to the supported ratios.
*/
`timescale 1ns/1ps
`include "apcm_defs.vh"
// Overview of operation
// - All timing is derived from the serial port; no master clock input exists.
// - The bit clock is the reference handed to the PLL, enabled only while clocks run.
// - The frame rate is classified automatically into 32k, 48k, 96k or 192k classes.
// - A stopped clock puts the processor to sleep and the outputs in high impedance.
// - Playback resumes by itself after clocks return, keeping the loaded program.
// - Data is shifted into the shift register one bit per bit-clock period.
// - Data is sampled on the rising edge of the bit clock.
// - The word clock is channel select in two-channel formats, frame sync in TDM.
// - In TDM a frame starts at the rising frame-sync edge, high at least one bit clock.
// - Two-channel formats accept 64 or 32 bit clocks per frame at 32 to 192 kHz.
// - TDM accepts 128 at 32k; 128/256/512 at 48k; 128/256 at 96k; 128 at 192k.
// - A clock halt or an unsupported ratio during play reports a clock error in the fault register.
// - On a halt during play all channels go high impedance and bit 2 of the fault register latches.
// - When clocks return the device goes back to its state before the halt.
module apcm_top #(
  parameter HALT_CYCLES = `APCM_HALT_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire bit_clock,
  input wire word_frame_clock,
  input wire serial_data_input,
  input wire tdm_mode,
  input wire play_request,
  input wire [7:0] reg_addr,
  input wire reg_read,
  input wire reg_write,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg [31:0] sample_word,
  output reg sample_valid,
  output reg sample_right,
  output reg [2:0] rate_class,
  output reg pll_enable,
  output reg dsp_sleep,
  output reg amp_hiz,
  output reg clock_error
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PLAY = 2'h1;
  localparam ST_HALT = 2'h2;

  wire sclk_rise;
  wire fs_level;
  wire fs_rise;
  wire fs_fall;
  wire sd_level;
  reg [1:0] state;
  reg [1:0] next_state;
  reg clocks_ok;
  reg [15:0] halt_count;
  reg [15:0] frame_cycles;
  reg [9:0] bits_in_frame;
  reg [9:0] last_ratio;
  reg [31:0] shifter;
  reg fs_seen;
  reg ratio_bad;
  reg [2:0] next_rate;

  // the three serial-port inputs are synchronised and edges are found from clk.
  apcm_sync u_sclk (.clk(clk), .rst(rst), .async_in(bit_clock),
    .level(), .rise(sclk_rise), .fall());
  apcm_sync u_fs (.clk(clk), .rst(rst), .async_in(word_frame_clock),
    .level(fs_level), .rise(fs_rise), .fall(fs_fall));
  apcm_sync u_sd (.clk(clk), .rst(rst), .async_in(serial_data_input),
    .level(sd_level), .rise(), .fall());

  // Frame period in system cycles maps to a rate class; bounds sit midway
  // between neighbouring rates so 44.1/48k and 88.2/96k share a class.
  function [2:0] classify;
    input [15:0] cyc;
    begin
      if (cyc > 16'd1500)
        classify = `APCM_RATE_NONE;
      else if (cyc > 16'd1050)
        classify = `APCM_RATE_32K;
      else if (cyc > 16'd620)
        classify = `APCM_RATE_48K;
      else if (cyc > 16'd310)
        classify = `APCM_RATE_96K;
      else if (cyc > 16'd150)
        classify = `APCM_RATE_192K;
      else
        classify = `APCM_RATE_NONE;
    end
  endfunction

  function ratio_ok;
    input tdm;
    input [2:0] rate;
    input [9:0] ratio;
    begin
      if (rate == `APCM_RATE_NONE)
        ratio_ok = 1'b0;
      else if (tdm == `APCM_FMT_TWO_CH)
        ratio_ok = (ratio == 10'd64) || (ratio == 10'd32);
      else if (rate == `APCM_RATE_48K)
        ratio_ok = (ratio == 10'd128) || (ratio == 10'd256) || (ratio == 10'd512);
      else if (rate == `APCM_RATE_96K)
        ratio_ok = (ratio == 10'd128) || (ratio == 10'd256);
      else
        ratio_ok = (ratio == 10'd128);
    end
  endfunction

  always @* begin
    next_rate = classify(frame_cycles);
  end

  // Halt detection: no bit-clock edge for the halt window means stopped.
  always @(posedge clk) begin
    if (rst) begin
      halt_count <= 16'h0000;
      clocks_ok <= 1'b0;
    end else if (sclk_rise) begin
      halt_count <= 16'h0000;
      clocks_ok <= fs_seen;
    end else if (halt_count >= HALT_CYCLES[15:0] - 16'h0001) begin
      clocks_ok <= 1'b0;
    end else begin
      halt_count <= halt_count + 16'h0001;
    end
  end

  // Frame measurement: a frame runs from one rising word clock to the next.
  always @(posedge clk) begin
    if (rst) begin
      frame_cycles <= 16'hffff;
      bits_in_frame <= 10'h000;
      last_ratio <= 10'h000;
      fs_seen <= 1'b0;
      rate_class <= `APCM_RATE_NONE;
      ratio_bad <= 1'b0;
    end else if (!clocks_ok && halt_count >= HALT_CYCLES[15:0] - 16'h0001) begin
      fs_seen <= 1'b0;
      frame_cycles <= 16'hffff;
      bits_in_frame <= 10'h000;
      rate_class <= `APCM_RATE_NONE;
      ratio_bad <= 1'b0;
    end else if (fs_rise) begin
      // Rising frame clock marks the frame start in both formats.
      fs_seen <= 1'b1;
      last_ratio <= bits_in_frame;
      bits_in_frame <= {9'h000, sclk_rise};
      frame_cycles <= 16'h0001;
      if (fs_seen) begin
        rate_class <= next_rate;
        ratio_bad <= !ratio_ok(tdm_mode, next_rate, bits_in_frame);
      end
    end else begin
      if (frame_cycles != 16'hffff)
        frame_cycles <= frame_cycles + 16'h0001;
      if (sclk_rise && bits_in_frame != 10'h3ff)
        bits_in_frame <= bits_in_frame + 10'h001;
    end
  end

  // Serial capture on bit-clock rising edges.
  always @(posedge clk) begin
    if (rst) begin
      shifter <= 32'h00000000;
      sample_word <= 32'h00000000;
      sample_valid <= 1'b0;
      sample_right <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (sclk_rise)
        shifter <= {shifter[30:0], sd_level};
      if (state == ST_PLAY && (fs_rise || (tdm_mode == `APCM_FMT_TWO_CH && fs_fall))) begin
        // Two-channel: each word-clock edge ends a channel word; TDM: frame.
        sample_word <= shifter;
        sample_valid <= 1'b1;
        // The word just captured belongs to the half that the edge has ended.
        sample_right <= (tdm_mode == `APCM_FMT_TWO_CH) ? ~fs_level : 1'b0;
      end
    end
  end

  // Operating state: the loaded program is untouched by a halt, so the
  // return to play needs no host action.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // Play waits for a judged frame so a bad ratio never plays briefly.
        if (play_request && clocks_ok && !ratio_bad && rate_class != `APCM_RATE_NONE)
          next_state = ST_PLAY;
      end
      ST_PLAY: begin
        if (!clocks_ok || ratio_bad)
          next_state = ST_HALT;
        else if (!play_request)
          next_state = ST_IDLE;
      end
      ST_HALT: begin
        if (!play_request)
          next_state = ST_IDLE;
        else if (clocks_ok && !ratio_bad && rate_class != `APCM_RATE_NONE)
          next_state = ST_PLAY;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      pll_enable <= 1'b0;
      dsp_sleep <= 1'b1;
      amp_hiz <= 1'b1;
    end else begin
      state <= next_state;
      pll_enable <= clocks_ok;
      dsp_sleep <= (next_state != ST_PLAY);
      amp_hiz <= (next_state != ST_PLAY);
    end
  end

  // Fault flag: the set wins over a host clear in the same cycle.
  always @(posedge clk) begin
    if (rst) begin
      clock_error <= 1'b0;
    end else if (state == ST_PLAY && (!clocks_ok || ratio_bad)) begin
      clock_error <= 1'b1;
    end else if (reg_write && reg_addr == `APCM_GLOBAL_FAULT_FLAGS_ADDR
                 && reg_wdata[`APCM_CLOCK_ERROR_BIT]) begin
      clock_error <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst)
      reg_rdata <= `APCM_GLOBAL_FAULT_FLAGS_RESET;
    else if (reg_read && reg_addr == `APCM_GLOBAL_FAULT_FLAGS_ADDR)
      reg_rdata <= {5'h00, clock_error, 2'h0};
    else if (reg_read)
      reg_rdata <= 8'h00;
  end
endmodule

// file: verif/apcm_host_model.sv
/* Host model driving bit clock, word/frame clock and serial data.
   Assumes run, tdm and ratio change only while the clocks stand still. */
`timescale 1ns/1ps
module apcm_host_model #(
  parameter logic [31:0] PAT = 32'h0000_0000
) (
  input wire run,
  input wire tdm,
  input wire [9:0] ratio,
  output reg bit_clock,
  output reg word_frame_clock,
  output reg serial_data_input
);
  integer n, half;
  initial begin
    bit_clock = 1'b0;
    word_frame_clock = 1'b0;
    serial_data_input = 1'b0;
    #37;
    forever begin
      half = tdm ? 32 : ratio / 2;
      // A stopped bit clock stands low, the word clock keeps its level; the released data line must not keep its last bit.
      if (!run) begin
        serial_data_input = ~serial_data_input;
        #100;
      end
      // Lines change on the falling edge, stable around the rise.
      for (n = 0; run && n < ratio; n = n + 1) begin
        word_frame_clock = tdm ? n == 0 : n >= half;
        serial_data_input = PAT[31 - n % half];
        #100 bit_clock = 1'b1;
        #100 bit_clock = 1'b0;
      end
    end
  end
endmodule

// file: verif/apcm_props.sv
/* Checker for apcm_top: register port, fault flag, halt and play.
   Assumes it sees only the top ports, all in the clk domain. */
`timescale 1ns/1ps
module apcm_props #(
  parameter HALT_CYCLES = 800
) (
  input wire clk,
  input wire rst,
  input wire bit_clock,
  input wire play_request,
  input wire [7:0] reg_addr,
  input wire reg_read,
  input wire reg_write,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [2:0] rate_class,
  input wire pll_enable,
  input wire amp_hiz,
  input wire clock_error
);
  logic [15:0] idle;
  wire clr = reg_write && reg_addr == 8'h71 && reg_wdata[2];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Raw pin low time; the margin of 16 covers the synchroniser and output registers.
  always @(posedge clk) begin
    if (rst || bit_clock) idle <= 16'h0000;
    else if (idle != 16'hffff) idle <= idle + 16'h0001;
  end
  AST_HALT_HIZ: assert property (idle > HALT_CYCLES + 16 |-> amp_hiz && !pll_enable)
    else $error("no halt");
  AST_READ_FAULT: assert property (reg_read && reg_addr == 8'h71 |=>
    reg_rdata == {5'h00, $past(clock_error), 2'h0}) else $error("bad fault read");
  AST_READ_OTHER: assert property (reg_read && reg_addr != 8'h71 |=> reg_rdata == 8'h00)
    else $error("bad other read");
  AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("rdata moved");
  AST_ERR_STICKY: assert property (clock_error && !clr |=> clock_error)
    else $error("flag lost");
  AST_ERR_CLEAR: assert property (amp_hiz [*3] ##0 clr |=> !clock_error)
    else $error("flag kept");
  AST_ERR_RISE: assert property ($rose(clock_error) |-> amp_hiz && !$past(amp_hiz, 2))
    else $error("flag without halt");
  AST_PLAY_CAUSE: assert property ($fell(amp_hiz) |->
    $past(play_request) && pll_enable && rate_class != 3'h0) else $error("play without cause");
  cover property ($rose(clock_error));
  cover property ($fell(amp_hiz));
  cover property (clr && clock_error);
endmodule
bind apcm_top apcm_props #(.HALT_CYCLES(HALT_CYCLES)) i_props (.clk, .rst, .bit_clock,
  .play_request, .reg_addr, .reg_read, .reg_write, .reg_wdata, .reg_rdata, .rate_class,
  .pll_enable, .amp_hiz, .clock_error);

// file: verif/test_audio_port_clock_monitor.sv
/* Bench for apcm_top: ratio table, halt, recovery, fault flag, reset.
   Assumes the host model drives the port; bit clock is 8 system clocks. */
`timescale 1ns/1ps
module test_audio_port_clock_monitor;
  typedef struct packed {logic t; logic [9:0] r; logic p; logic [2:0] c;} apcm_row_t;
  localparam logic [31:0] PAT = 32'hc3a5_96f1;
  apcm_row_t rows [5] = '{'{1'b0, 10'h040, 1'b1, 3'h3}, '{1'b0, 10'h020, 1'b1, 3'h4},
    '{1'b1, 10'h080, 1'b1, 3'h2}, '{1'b1, 10'h100, 1'b0, 3'h0}, '{1'b0, 10'h030, 1'b0, 3'h3}};
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, tdm_mode = 1'b0, play_request = 1'b0;
  logic reg_read = 1'b0, reg_write = 1'b0, chk_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [9:0] ratio = 10'h040;
  wire bit_clock, word_frame_clock, serial_data_input, sample_valid, sample_right;
  wire pll_enable, dsp_sleep, amp_hiz, clock_error;
  wire [7:0] reg_rdata;
  wire [31:0] sample_word;
  wire [2:0] rate_class;
  int err_count = 0, n_compared = 0, cyc = 0;
  always #12.5 clk = ~clk;
  apcm_host_model #(.PAT(PAT)) i_host (.run, .tdm(tdm_mode), .ratio, .bit_clock,
    .word_frame_clock, .serial_data_input);
  apcm_top #(.HALT_CYCLES(64)) i_dut (.clk, .rst, .bit_clock, .word_frame_clock,
    .serial_data_input, .tdm_mode, .play_request, .reg_addr, .reg_read, .reg_write, .reg_wdata,
    .reg_rdata, .sample_word, .sample_valid, .sample_right, .rate_class, .pll_enable,
    .dsp_sleep, .amp_hiz, .clock_error);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic halt;
    @(posedge clk);
    chk_en <= 1'b0;
    run <= 1'b0;
    tick(4000);
    #1;
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (chk_en && sample_valid) check(sample_word, ratio == 10'h020 ? {2{PAT[31:16]}} : PAT);
    if (chk_en && sample_valid) check(sample_right, tdm_mode ? 1'b0 : !word_frame_clock);
    if (cyc == 80000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    tick(16);
    rst <= 1'b0;
    play_request <= 1'b1;
    foreach (rows[i]) begin
      tdm_mode <= rows[i].t;
      ratio <= rows[i].r;
      run <= 1'b1;
      chk_en <= rows[i].p;
      tick(rows[i].r * 40);
      #1 check(amp_hiz, !rows[i].p);
      check(rate_class, rows[i].c);
      check(pll_enable, 1'b1);
      halt;
      check(dsp_sleep, 1'b1);
      check(clock_error, rows[i].p);
      reg_wr(8'h71, 8'h04);
    end
    tdm_mode <= 1'b0;
    ratio <= 10'h040;
    run <= 1'b1;
    tick(2560);
    halt;
    @(posedge clk);
    run <= 1'b1;
    tick(2560);
    #1 check(amp_hiz, 1'b0);
    check(clock_error, 1'b1);
    reg_rd(8'h71, 8'h04);
    reg_wr(8'h70, 8'h04);
    reg_rd(8'h71, 8'h04);
    reg_rd(8'h70, 8'h00);
    reg_wr(8'h71, 8'h04);
    reg_rd(8'h71, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    tick(16);
    rst <= 1'b0;
    @(posedge clk);
    #1 check({amp_hiz, dsp_sleep, pll_enable, clock_error, rate_class}, 7'h60);
    reg_rd(8'h71, 8'h00);
    end_of_test;
  end
endmodule
